// >>> dar_cfg.svh
// Constants for the DMA activation request logic
`ifndef DAR_CFG_SVH
`define DAR_CFG_SVH

// Source select codes per channel; 0 to A are peripheral interrupts
`define DAR_SRC_INT_LAST    4'hA
`define DAR_SRC_EXT_EDGE    4'hC
`define DAR_SRC_EXT_LEVEL   4'hD
`define DAR_SRC_AUTO        4'hE

// Interrupt lines whose flag clears only on a register access
`define DAR_IRQ_ACCESS_MASK 11'h01F

// Request queue shape
`define DAR_FIFO_WIDTH      3
`define DAR_FIFO_DEPTH      8

// Reset values
`define DAR_RST_CH          4'h0
`define DAR_RST_IRQ         11'h000
`define DAR_PIN_IDLE        1'b1

`endif

// >>> dar_pkg.sv
// Types shared by the DMA activation request logic
package dar_pkg;

  typedef logic [3:0] dar_sel_type;
  typedef logic [1:0] dar_chan_type;

  // Auto-request run state of one channel
  typedef enum logic {
    AUTO_IDLE,
    AUTO_RUN
  } dar_auto_type;

endpackage

// >>> dar_req_sync.sv
// Synchroniser and falling-edge detector for one external request pin
`timescale 1ns/1ns
`include "dar_cfg.svh"

module dar_req_sync (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rstn_i,
  // Pin side, active low
  input  wire logic pin_n_i,
  // Synchronised view
  output logic      low_o,
  output logic      fall_o
);

  logic meta_ff;
  logic sync_ff;
  logic prev_ff;

  // Idle level is high so a reset never fakes an edge
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      meta_ff <= `DAR_PIN_IDLE;
      sync_ff <= `DAR_PIN_IDLE;
      prev_ff <= `DAR_PIN_IDLE;
    end else begin
      meta_ff <= pin_n_i;
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
    end
  end

  assign low_o  = ~sync_ff;
  assign fall_o = prev_ff & ~sync_ff;

endmodule

// >>> dar_fifo.sv
// Small synchronous FIFO with valid and ready on both sides
`timescale 1ns/1ns
`include "dar_cfg.svh"

module dar_fifo #(
  parameter int W = `DAR_FIFO_WIDTH,
  parameter int D = `DAR_FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rstn_i,
  // Fill side
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  // Drain side
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);

  localparam int AW = $clog2(D);

  logic [W-1:0]  mem_ff [D];
  logic [AW-1:0] wr_ff;
  logic [AW-1:0] rd_ff;
  logic [AW:0]   cnt_ff;
  logic          push;
  logic          pop;

  assign in_ready_o  = cnt_ff != (AW+1)'(D);
  assign out_valid_o = cnt_ff != '0;
  assign out_data_o  = mem_ff[rd_ff];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_ff[wr_ff] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      wr_ff <= '0;
      rd_ff <= '0;
    end else begin
      if (push) begin
        wr_ff <= (wr_ff == AW'(D-1)) ? '0 : wr_ff + 1'b1;
      end
      if (pop) begin
        rd_ff <= (rd_ff == AW'(D-1)) ? '0 : rd_ff + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

endmodule

// >>> dar_top.sv
// Activation request front end of a four-channel DMA controller
`timescale 1ns/1ns
`include "dar_cfg.svh"

// How it works
// - Short channels and block-mode pairs take the eleven interrupts; full normal does not.
// - External pin selectable on second channel of short pair or in full modes only.
// - Auto-request only in full normal mode; runs from enable until count ends.
// - A claimed peripheral interrupt is withheld from the processor side.
// - Peripheral interrupts are taken directly, free of interrupt controller priority.
// - With controller select 1, the DMA transfer clears the source flag.
// - Converter and serial flags clear only when the transfer touches their register.
// - Shared source clears as top channel starts; others pend, served by priority.
// - Disabled channel leaves its source to the processor side, whatever the select.
// - With controller select 0 the DMA never clears the flag.
// - Edge sensing moves exactly one unit per falling edge detected while the channel is idle.
// - Level sensing idles while the request pin is high.
// - Pin held low gives back-to-back units, bus released after each.
// - Pin returning high mid-run suspends the run and waits again.
// - Auto-request offers a choice of cycle-steal or burst ownership.
// - Cycle steal releases the bus after every unit.
// - Burst keeps the bus until the whole programmed transfer ends.
module dar_top (
  // Clock and reset
  input  wire logic        REF_CLK_I,
  input  wire logic        RSTN_I,
  // Channel setup, bit order 0A 0B 1A 1B
  input  wire logic [3:0]  CHANNEL_TRANSFER_ENABLE_I,
  input  wire logic [3:0]  TRANSFER_CONTROLLER_SELECT_I,
  input  wire logic [15:0] SRC_SEL_I,
  // Pair setup, bit 0 pair 0, bit 1 pair 1
  input  wire logic [1:0]  FULL_ADDR_I,
  input  wire logic [1:0]  BLOCK_MODE_I,
  input  wire logic [1:0]  BURST_I,
  // Peripheral interrupt lines
  input  wire logic [10:0] PERIPH_IRQ_I,
  input  wire logic [10:0] PERIPH_ACCESS_I,
  output logic      [10:0] HOST_IRQ_O,
  output logic      [10:0] FLAG_CLR_O,
  // External request pins, one per pair
  input  wire logic [1:0]  EXT_DMA_REQUEST_N_I,
  // Transfer engine
  output logic             REQ_VALID_O,
  input  wire logic        REQ_READY_I,
  output logic      [1:0]  REQ_CHAN_O,
  output logic             REQ_BURST_O,
  input  wire logic        XFER_DONE_I,
  input  wire logic [1:0]  XFER_CHAN_I,
  input  wire logic        COUNT_END_I,
  // Status
  output logic             BUS_HOLD_O,
  output logic      [3:0]  PENDING_O,
  output logic      [3:0]  ACTIVE_O
);

  localparam logic [10:0] ACC_MASK = `DAR_IRQ_ACCESS_MASK;

  //--------------------------------------------------------------------
  // Signals
  //--------------------------------------------------------------------
  dar_pkg::dar_sel_type  sel [4];
  dar_pkg::dar_auto_type auto_ff [4];
  dar_pkg::dar_chan_type grant_ch;

  logic [3:0]  ok_int;
  logic [3:0]  ok_ext;
  logic [3:0]  ok_auto;
  logic [3:0]  is_edge;
  logic [3:0]  is_lvl;
  logic [3:0]  int_hit;
  logic [3:0]  edge_hit;
  logic [3:0]  lvl_want;
  logic [3:0]  auto_want;
  logic [3:0]  want;
  logic [3:0]  grant;
  logic [3:0]  done_ch;
  logic [3:0]  pend_ff;
  logic [3:0]  busy_ff;
  logic [3:0]  en_q_ff;
  logic [3:0]  nxt_pend;
  logic [3:0]  nxt_busy;
  logic [10:0] irq_q_ff;
  logic [10:0] irq_rise;
  logic [10:0] claim;
  logic [10:0] nxt_clr;
  logic [1:0]  pin_low;
  logic [1:0]  pin_fall;
  logic        any_grant;
  logic        burst_sel;
  logic        fifo_in_ready;
  logic        hold_ff;
  logic        nxt_hold;

  //--------------------------------------------------------------------
  // External request pins
  //--------------------------------------------------------------------
  for (genvar p = 0; p < 2; p++) begin : g_pin
    dar_req_sync u_sync (
      .clk_i   (REF_CLK_I),
      .rstn_i  (RSTN_I),
      .pin_n_i (EXT_DMA_REQUEST_N_I[p]),
      .low_o   (pin_low[p]),
      .fall_o  (pin_fall[p])
    );
  end

  //--------------------------------------------------------------------
  // Source legality per channel and mode
  //--------------------------------------------------------------------
  always_comb begin
    logic full;
    logic blk;
    logic isb;
    full = 1'b0;
    blk  = 1'b0;
    isb  = 1'b0;
    for (int c = 0; c < 4; c++) begin
      sel[c]     = SRC_SEL_I[4*c +: 4];
      full       = FULL_ADDR_I[c/2];
      blk        = BLOCK_MODE_I[c/2];
      isb        = (c % 2) == 1;
      ok_int[c]  = (sel[c] <= `DAR_SRC_INT_LAST) & (~full | (blk & ~isb));
      is_edge[c] = sel[c] == `DAR_SRC_EXT_EDGE;
      is_lvl[c]  = sel[c] == `DAR_SRC_EXT_LEVEL;
      ok_ext[c]  = (is_edge[c] | is_lvl[c]) & (full ? ~isb : isb);
      ok_auto[c] = (sel[c] == `DAR_SRC_AUTO) & full & ~blk & ~isb;
    end
  end

  //--------------------------------------------------------------------
  // Interrupt ownership and routing
  //--------------------------------------------------------------------
  // Lines come from on-chip logic on this clock, so no synchroniser
  assign irq_rise = PERIPH_IRQ_I & ~irq_q_ff;

  always_comb begin
    claim = '0;
    for (int c = 0; c < 4; c++) begin
      if (ok_int[c] && CHANNEL_TRANSFER_ENABLE_I[c] && TRANSFER_CONTROLLER_SELECT_I[c]) begin
        claim[sel[c]] = 1'b1;
      end
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (!RSTN_I) begin
      irq_q_ff   <= `DAR_RST_IRQ;
      HOST_IRQ_O <= `DAR_RST_IRQ;
    end else begin
      irq_q_ff   <= PERIPH_IRQ_I;
      HOST_IRQ_O <= PERIPH_IRQ_I & ~claim;
    end
  end

  //--------------------------------------------------------------------
  // Request detection
  //--------------------------------------------------------------------
  always_comb begin
    for (int c = 0; c < 4; c++) begin
      int_hit[c] = 1'b0;
      if (ok_int[c]) begin
        int_hit[c] = CHANNEL_TRANSFER_ENABLE_I[c] & irq_rise[sel[c]];
      end
      // An edge while the channel is still busy is dropped
      edge_hit[c]  = ok_ext[c] & is_edge[c] & CHANNEL_TRANSFER_ENABLE_I[c]
                   & pin_fall[c/2] & ~busy_ff[c] & ~pend_ff[c];
      lvl_want[c]  = ok_ext[c] & is_lvl[c] & CHANNEL_TRANSFER_ENABLE_I[c]
                   & pin_low[c/2] & ~busy_ff[c];
      // Both styles keep one unit in flight; burst differs by bus hold
      auto_want[c] = (auto_ff[c] == dar_pkg::AUTO_RUN) & ~busy_ff[c];
      want[c]      = (pend_ff[c] & ~busy_ff[c]) | lvl_want[c] | auto_want[c];
    end
  end

  //--------------------------------------------------------------------
  // Priority arbiter, 0A highest
  //--------------------------------------------------------------------
  always_comb begin
    grant    = '0;
    grant_ch = 2'h0;
    for (int c = 3; c >= 0; c--) begin
      if (want[c] && fifo_in_ready) begin
        grant    = '0;
        grant[c] = 1'b1;
        grant_ch = 2'(c);
      end
    end
  end

  assign any_grant = |grant;
  assign burst_sel = BURST_I[grant_ch[1]] & (auto_ff[grant_ch] == dar_pkg::AUTO_RUN);
  assign done_ch   = XFER_DONE_I ? 4'(4'h1 << XFER_CHAN_I) : 4'h0;

  //--------------------------------------------------------------------
  // Pending and in-flight state
  //--------------------------------------------------------------------
  // A new hit wins over the grant that consumes the old one
  assign nxt_pend = (pend_ff & ~grant & CHANNEL_TRANSFER_ENABLE_I) | int_hit | edge_hit;
  assign nxt_busy = (busy_ff & ~done_ch) | grant;

  always_ff @(posedge REF_CLK_I) begin
    if (!RSTN_I) begin
      pend_ff <= `DAR_RST_CH;
      busy_ff <= `DAR_RST_CH;
      en_q_ff <= `DAR_RST_CH;
    end else begin
      pend_ff <= nxt_pend;
      busy_ff <= nxt_busy;
      en_q_ff <= CHANNEL_TRANSFER_ENABLE_I;
    end
  end

  //--------------------------------------------------------------------
  // Auto-request run
  //--------------------------------------------------------------------
  always_ff @(posedge REF_CLK_I) begin
    for (int c = 0; c < 4; c++) begin
      if (!RSTN_I) begin
        auto_ff[c] <= dar_pkg::AUTO_IDLE;
      end else begin
        unique case (auto_ff[c])
          dar_pkg::AUTO_IDLE: begin
            if (ok_auto[c] && CHANNEL_TRANSFER_ENABLE_I[c] && !en_q_ff[c]) begin
              auto_ff[c] <= dar_pkg::AUTO_RUN;
            end
          end
          dar_pkg::AUTO_RUN: begin
            if (!CHANNEL_TRANSFER_ENABLE_I[c] || (done_ch[c] && COUNT_END_I)) begin
              auto_ff[c] <= dar_pkg::AUTO_IDLE;
            end
          end
        endcase
      end
    end
  end

  //--------------------------------------------------------------------
  // Bus ownership
  //--------------------------------------------------------------------
  always_comb begin
    nxt_hold = 1'b0;
    for (int c = 0; c < 4; c++) begin
      if (auto_ff[c] == dar_pkg::AUTO_RUN && BURST_I[c/2]) begin
        nxt_hold = 1'b1;
      end
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (!RSTN_I) begin
      hold_ff <= 1'b0;
    end else begin
      hold_ff <= nxt_hold;
    end
  end

  assign BUS_HOLD_O = hold_ff;

  //--------------------------------------------------------------------
  // Source flag clearing
  //--------------------------------------------------------------------
  always_comb begin
    logic first;
    first   = 1'b1;
    nxt_clr = PERIPH_ACCESS_I & claim & ACC_MASK;
    for (int c = 0; c < 4; c++) begin
      first = 1'b1;
      for (int h = 0; h < c; h++) begin
        // Only the top channel on a shared source clears, never a later one
        if (CHANNEL_TRANSFER_ENABLE_I[h] && ok_int[h] && sel[h] == sel[c]) begin
          first = 1'b0;
        end
      end
      if (grant[c] && pend_ff[c] && ok_int[c] && first
          && TRANSFER_CONTROLLER_SELECT_I[c] && !ACC_MASK[sel[c]]) begin
        nxt_clr[sel[c]] = 1'b1;
      end
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (!RSTN_I) begin
      FLAG_CLR_O <= `DAR_RST_IRQ;
    end else begin
      FLAG_CLR_O <= nxt_clr;
    end
  end

  //--------------------------------------------------------------------
  // Request queue toward the transfer engine
  //--------------------------------------------------------------------
  // Entries already queued still run if a level pin rises late
  dar_fifo #(
    .W (`DAR_FIFO_WIDTH),
    .D (`DAR_FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (REF_CLK_I),
    .rstn_i      (RSTN_I),
    .in_valid_i  (any_grant),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   ({burst_sel, grant_ch}),
    .out_valid_o (REQ_VALID_O),
    .out_ready_i (REQ_READY_I),
    .out_data_o  ({REQ_BURST_O, REQ_CHAN_O})
  );

  assign PENDING_O = pend_ff;
  assign ACTIVE_O  = busy_ff;

  //--------------------------------------------------------------------
  // Assertions
  //--------------------------------------------------------------------
  default clocking cb @(posedge REF_CLK_I);
  endclocking
  default disable iff (!RSTN_I);

  sequence s_edge_armed;
    !FULL_ADDR_I[0] && is_edge[1] && CHANNEL_TRANSFER_ENABLE_I[1]
      && !busy_ff[1] && !pend_ff[1];
  endsequence

  sequence s_edge_seen;
    s_edge_armed ##0 pin_fall[0];
  endsequence

  sequence s_lvl_ready;
    !FULL_ADDR_I[0] && is_lvl[1] && CHANNEL_TRANSFER_ENABLE_I[1]
      && pin_low[0] && !busy_ff[1] && !want[0] && fifo_in_ready;
  endsequence

  a_full_no_int: assert property (
    (FULL_ADDR_I[0] && !BLOCK_MODE_I[0] && !pend_ff[0]
      && SRC_SEL_I[3:0] <= `DAR_SRC_INT_LAST) |=> !pend_ff[0])
    else $error("full normal mode took an interrupt");

  a_chan_a_ext: assert property (
    (!FULL_ADDR_I[0] && is_edge[0] && !pend_ff[0]) |=> !pend_ff[0])
    else $error("first channel took the external pin");

  a_auto_keeps: assert property (
    (auto_ff[0] == dar_pkg::AUTO_RUN && CHANNEL_TRANSFER_ENABLE_I[0]
      && !(done_ch[0] && COUNT_END_I)) |=> auto_ff[0] == dar_pkg::AUTO_RUN)
    else $error("auto run stopped before count end");

  a_host_pass: assert property (
    (PERIPH_IRQ_I[5] && TRANSFER_CONTROLLER_SELECT_I == 4'h0) |=> HOST_IRQ_O[5])
    else $error("interrupt not passed to processor side");

  a_off_routes: assert property (
    (PERIPH_IRQ_I[6] && CHANNEL_TRANSFER_ENABLE_I == 4'h0) |=> HOST_IRQ_O[6])
    else $error("disabled channel kept the interrupt");

  a_no_clear: assert property (
    (TRANSFER_CONTROLLER_SELECT_I == 4'h0) |=> FLAG_CLR_O == 11'h000)
    else $error("flag cleared with select at zero");

  a_access_clear: assert property (
    FLAG_CLR_O[0] |-> $past(PERIPH_ACCESS_I[0]))
    else $error("converter flag cleared without access");

  a_one_grant: assert property (
    $onehot0(grant))
    else $error("more than one channel granted");

  a_edge_pends: assert property (
    s_edge_seen |=> pend_ff[1] ##1 !edge_hit[1] || busy_ff[1] || pend_ff[1])
    else $error("falling edge did not register a request");

  a_level_idle: assert property (
    (is_lvl[1] && !pin_low[0] && !pend_ff[1]) |-> !grant[1])
    else $error("level channel ran with pin high");

  a_level_runs: assert property (
    s_lvl_ready |-> grant[1] ##1 busy_ff[1])
    else $error("level channel did not start with pin low");

  a_steal_single: assert property (
    busy_ff[0] |-> !grant[0])
    else $error("second unit issued before release");

  a_burst_hold: assert property (
    (auto_ff[0] == dar_pkg::AUTO_RUN && BURST_I[0]) |=> BUS_HOLD_O)
    else $error("burst run dropped the bus");

endmodule

// >>> dar_far_end.sv
// Far-side model: peripheral interrupt flags and the transfer engine
`timescale 1ns/1ns

module dar_far_end (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  // Peripheral flags
  input  wire logic [10:0] set_i,
  input  wire logic [10:0] clr_i,
  output logic      [10:0] irq_o,
  // Engine setup
  input  wire logic [15:0] sel_i,
  input  wire logic        acc_on_i,
  input  wire logic        stall_i,
  input  wire logic [7:0]  limit_i,
  // Engine side
  input  wire logic        valid_i,
  input  wire logic [1:0]  chan_i,
  output logic             ready_o,
  output logic             done_o,
  output logic      [1:0]  done_chan_o,
  output logic             end_o,
  output logic      [10:0] access_o,
  output logic      [31:0] units_o
);
  logic       busy_ff;
  logic [1:0] chan_ff;
  logic [2:0] wait_ff;

  // Flag stays set until cleared, as a real peripheral would
  always_ff @(posedge clk_i) begin
    if (!rstn_i)
      irq_o <= 11'h000;
    else
      irq_o <= (irq_o | set_i) & ~clr_i;
  end

  assign ready_o = !busy_ff && !stall_i;
  // Channel lines show garbage outside a completion
  assign done_chan_o = done_o ? chan_ff : ~chan_ff;
  assign end_o = done_o && (units_o[{chan_ff, 3'h0} +: 8] + 8'h01 == limit_i);
  // Register touch lands one cycle before the unit completes
  assign access_o = (busy_ff && wait_ff == 3'h0 && !done_o && acc_on_i) ?
                    (11'h001 << sel_i[{chan_ff, 2'h0} +: 4]) & 11'h01F : 11'h000;

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      busy_ff <= 1'b0;
      chan_ff <= 2'h0;
      wait_ff <= 3'h0;
      done_o  <= 1'b0;
      units_o <= 32'h0;
    end else begin
      done_o <= 1'b0;
      if (valid_i && ready_o) begin
        busy_ff <= 1'b1;
        chan_ff <= chan_i;
        wait_ff <= 3'h2;
      end else if (busy_ff && !done_o) begin
        if (wait_ff != 3'h0)
          wait_ff <= wait_ff - 3'h1;
        else
          done_o <= 1'b1;
      end
      if (done_o) begin
        busy_ff <= 1'b0;
        units_o[{chan_ff, 3'h0} +: 8] <= units_o[{chan_ff, 3'h0} +: 8] + 8'h01;
      end
    end
  end
endmodule

// >>> dma_activation_request_logic_test.sv
// Self-checking bench for the DMA activation request logic
`timescale 1ns/1ns

module dma_activation_request_logic_test;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic [3:0]  en = 4'h0;
  logic [3:0]  tsel = 4'h0;
  logic [15:0] sel = 16'h0000;
  logic [1:0]  full = 2'h0;
  logic [1:0]  blk = 2'h0;
  logic [1:0]  burst = 2'h0;
  logic [10:0] irq_set = 11'h000;
  logic [10:0] swclr = 11'h000;
  logic [1:0]  pin = 2'h3;
  logic        stall = 1'b0;
  logic        acc_on = 1'b1;
  logic        rnd_on = 1'b0;
  logic [7:0]  limit = 8'hFF;
  logic [10:0] irq, host, fclr, acc;
  logic        rv, rr, rb, done, cend, hold, hold_prev;
  logic [1:0]  rch, dch;
  logic [3:0]  pend, act;
  logic [31:0] units;
  int          miscompares = 0;
  int          total_checks = 0;
  int          hold_drops = 0;
  int          burst_pops = 0;
  int          clr_cnt [11];
  logic [1:0]  order [$];

  dar_top dut (
    .REF_CLK_I(clk), .RSTN_I(rstn), .CHANNEL_TRANSFER_ENABLE_I(en),
    .TRANSFER_CONTROLLER_SELECT_I(tsel), .SRC_SEL_I(sel), .FULL_ADDR_I(full),
    .BLOCK_MODE_I(blk), .BURST_I(burst), .PERIPH_IRQ_I(irq), .PERIPH_ACCESS_I(acc),
    .HOST_IRQ_O(host), .FLAG_CLR_O(fclr), .EXT_DMA_REQUEST_N_I(pin), .REQ_VALID_O(rv),
    .REQ_READY_I(rr), .REQ_CHAN_O(rch), .REQ_BURST_O(rb), .XFER_DONE_I(done),
    .XFER_CHAN_I(dch), .COUNT_END_I(cend), .BUS_HOLD_O(hold), .PENDING_O(pend),
    .ACTIVE_O(act));

  dar_far_end far (
    .clk_i(clk), .rstn_i(rstn), .set_i(irq_set), .clr_i(fclr | swclr), .irq_o(irq),
    .sel_i(sel), .acc_on_i(acc_on), .stall_i(stall), .limit_i(limit), .valid_i(rv),
    .chan_i(rch), .ready_o(rr), .done_o(done), .done_chan_o(dch), .end_o(cend),
    .access_o(acc), .units_o(units));

  // ----------------------------------------
  // Clock, stalls and monitors
  // ----------------------------------------
  always #5 clk = ~clk;

  always @(posedge clk) #1 stall = rnd_on && ($urandom % 3 == 0);

  always @(posedge clk) begin
    hold_prev <= hold;
    if (hold_prev === 1'b1 && hold !== 1'b1) hold_drops++;
    if (rv === 1'b1 && rr === 1'b1) order.push_back(rch);
    if (rv === 1'b1 && rr === 1'b1 && rb === 1'b1) burst_pops++;
    for (int i = 0; i < 11; i++)
      if (fclr[i] === 1'b1) clr_cnt[i]++;
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic cfg(input logic [3:0] e, input logic [3:0] t, input logic [15:0] s,
                     input logic [1:0] f, input logic [1:0] b, input logic [1:0] bu);
    tick(1);
    en = e;
    tsel = t;
    sel = s;
    full = f;
    blk = b;
    burst = bu;
    clr_cnt = '{default: 0};
    swclr = 11'h7FF;
    tick(1);
    swclr = 11'h000;
  endtask

  task automatic fire(input int s);
    irq_set[s] = 1'b1;
    tick(1);
    irq_set = 11'h000;
    tick(16);
  endtask

  function automatic logic [7:0] u(input int c);
    return units[c*8 +: 8];
  endfunction

  // Mode 0 short, 1 block, 2 full normal; block mode uses the A slot only
  function automatic logic takes_irq(input int ch, input int m);
    return (m == 0) || (m == 1 && ch % 2 == 0);
  endfunction

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    logic [7:0] u0, u1;
    int ch, m, n;
    logic t, tk;
    void'($urandom(33957));
    rnd_on = 1'b1;
    tick(12);
    rstn = 1'b1;
    tick(1);
    chk({host, fclr, rv, hold, pend, act}, 32'h0);
    for (int s = 0; s < 11; s++) begin
      ch = $urandom % 4;
      m = s % 3;
      t = $urandom % 2;
      acc_on = (s != 2);
      tk = takes_irq(ch, m);
      cfg(4'h1 << ch, {4{t}}, {4{s[3:0]}}, (m != 0) ? 2'h3 : 2'h0, (m == 1) ? 2'h3 : 2'h0, 2'h0);
      u0 = u(ch);
      fire(s);
      chk(u(ch) - u0, tk);
      chk(clr_cnt[s], tk && t && (s > 4 || acc_on));
      if (tk) chk(host[s], !t);
    end
    acc_on = 1'b1;
    cfg(4'h0, 4'hF, 16'h7777, 2'h0, 2'h0, 2'h0);
    u0 = u(0);
    fire(7);
    chk(u(0) - u0, 0);
    chk(host[7], 1'b1);
    cfg(4'h3, 4'hF, 16'h0066, 2'h0, 2'h0, 2'h0);
    order.delete();
    fire(6);
    chk(clr_cnt[6], 1);
    chk(order.size(), 2);
    chk(order[0], 0);
    chk(order[1], 1);
    // Both slots of pair 0 on the edge source; the A slot must stay deaf
    cfg(4'h3, 4'h0, 16'h00CC, 2'h0, 2'h0, 2'h0);
    u0 = u(0);
    u1 = u(1);
    n = 1 + $urandom % 4;
    for (int k = 0; k < n; k++) begin
      pin[0] = 1'b0;
      for (int w = 0; w < 40 && u(1) == u1 + k; w++) tick(1);
      pin[0] = 1'b1;
      tick(4);
    end
    chk(u(1) - u1, n);
    chk(u(0) - u0, 0);
    cfg(4'h8, 4'h0, 16'hD000, 2'h0, 2'h0, 2'h0);
    u0 = u(3);
    hold_drops = 0;
    tick(20);
    chk(u(3) - u0, 0);
    pin[1] = 1'b0;
    tick(40);
    chk(u(3) - u0 > 2, 1);
    chk(hold_drops, 0);
    chk(hold, 1'b0);
    pin[1] = 1'b1;
    tick(15);
    u0 = u(3);
    tick(30);
    chk(u(3) - u0, 0);
    chk({pend, act}, 8'h00);
    // Auto runs: short mode ignored, then cycle steal, then burst
    for (int k = 0; k < 3; k++) begin
      cfg(4'h0, 4'h0, 16'h000E, (k > 0) ? 2'h1 : 2'h0, 2'h0, (k == 2) ? 2'h1 : 2'h0);
      n = 2 + $urandom % 5;
      u0 = u(0);
      limit = u0 + n[7:0];
      hold_drops = 0;
      burst_pops = 0;
      en = 4'h1;
      tick(120);
      chk(u(0) - u0, (k > 0) ? n : 0);
      chk(hold_drops, k == 2);
      chk(burst_pops, (k == 2) ? n : 0);
      chk(hold, 1'b0);
    end
    stop_test();
  end

  initial begin
    repeat (5000) @(posedge clk);
    miscompares++;
    stop_test();
  end
endmodule
